//--- hw/quadrature_displacement_output.sv
// quadrature pulse generator following a scale position count
`timescale 1ns/1ps
module quadrature_displacement_output #(
   parameter int POS_W = 24
) (
   input  wire logic                      mclk,
   input  wire logic                      resetn,
   input  wire logic [POS_W-1:0]          scale_position,
   input  wire logic [1:0]                resolution_sel,
   input  wire logic                      overspeed,
   input  wire logic                      detect_fault,
   input  wire logic                      origin_mark,
   output logic                           phase_a_true,
   output logic                           phase_a_comp,
   output logic                           phase_b_true,
   output logic                           phase_b_comp,
   output logic                           origin_pulse_out,
   output logic                           origin_pulse_comp,
   output logic                           error_active,
   output logic                           lag_overrun
);
   import quad_out_pkg::*;

   // position difference sign needs a few bits; counters stay within one word
   if (POS_W < 4 || POS_W > 32) begin : g_bad_pos_w
      $error("POS_W out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // emitted position chases the scale position one step per gap
   logic [POS_W-1:0]  emitted_reg;
   logic [CNT_W-1:0]  gap_reg;
   logic [CNT_W-1:0]  lag_reg;
   logic [1:0]        quad_reg;
   logic              err_a_reg;
   out_state_t        state_reg;
   logic              origin_reg;
   logic              lag_over_reg;

   wire logic [CNT_W-1:0] gap_limit = (resolution_sel == RES_1UM)
                                      ? CNT_W'(GAP_COARSE_CYC - 1) : CNT_W'(GAP_FINE_CYC - 1);
   wire logic [POS_W-1:0] diff      = scale_position - emitted_reg;
   wire logic             behind    = (diff != '0);
   wire logic             go_up     = ~diff[POS_W-1];  // retracting counts up
   wire logic             gap_done  = (gap_reg >= gap_limit);
   wire logic             fault     = overspeed | detect_fault;
   wire logic             step_ok   = behind & gap_done;
   // gray sequence (A,B) 00,10,11,01: A leads B while counting up
   wire logic [1:0]       quad_up   = {~quad_reg[0], quad_reg[1]};
   wire logic [1:0]       quad_dn   = {quad_reg[0], ~quad_reg[1]};
   wire logic             err_tick  = (gap_reg >= CNT_W'(ERR_WIDTH_CYC - 1));

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         emitted_reg  <= '0;
         gap_reg      <= '0;
         lag_reg      <= '0;
         quad_reg     <= 2'h0;
         err_a_reg    <= 1'b0;
         state_reg    <= ST_TRACK;
         origin_reg   <= 1'b0;
         lag_over_reg <= 1'b0;
      end else begin
         origin_reg <= origin_mark & ~fault;
         case (state_reg)
            ST_TRACK: begin
               if (fault) begin
                  state_reg <= ST_ERROR;
                  gap_reg   <= '0;
               end else if (step_ok) begin
                  emitted_reg <= go_up ? emitted_reg + 1'b1 : emitted_reg - 1'b1;
                  quad_reg    <= go_up ? quad_up : quad_dn;
                  gap_reg     <= '0;
               end else if (!gap_done) begin
                  gap_reg <= gap_reg + 1'b1;
               end
               // count how long we have trailed; flag a miss of the delay budget
               if (behind && !fault) begin
                  if (lag_reg < CNT_W'(OUT_DELAY_CYC)) lag_reg <= lag_reg + 1'b1;
                  else lag_over_reg <= 1'b1;
               end else begin
                  lag_reg      <= '0;
                  lag_over_reg <= 1'b0;
               end
            end
            ST_ERROR: begin
               // resync at the scale on exit; counts from the error span are void
               lag_reg <= '0;
               if (err_tick) begin
                  gap_reg   <= '0;
                  err_a_reg <= ~err_a_reg;
                  if (!fault) begin
                     state_reg   <= ST_TRACK;
                     emitted_reg <= scale_position;
                  end
               end else begin
                  gap_reg <= gap_reg + 1'b1;
               end
            end
            default: state_reg <= ST_TRACK;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   wire logic in_err = (state_reg == ST_ERROR);
   wire logic a_nxt  = in_err ? err_a_reg : quad_reg[1];
   wire logic b_nxt  = in_err ? err_a_reg : quad_reg[0];

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         phase_a_true      <= 1'b0;
         phase_a_comp      <= 1'b1;
         phase_b_true      <= 1'b0;
         phase_b_comp      <= 1'b1;
         origin_pulse_out  <= 1'b0;
         origin_pulse_comp <= 1'b1;
         error_active      <= 1'b0;
         lag_overrun       <= 1'b0;
      end else begin
         phase_a_true      <= a_nxt;
         phase_a_comp      <= ~a_nxt;
         phase_b_true      <= b_nxt;
         phase_b_comp      <= ~b_nxt;
         origin_pulse_out  <= origin_reg;
         origin_pulse_comp <= ~origin_reg;
         error_active      <= in_err;
         lag_overrun       <= lag_over_reg;
      end
   end
endmodule : quadrature_displacement_output

//--- hw/quad_out_pkg.sv
// constants for the quadrature displacement output block
// Function
// - two square phases with complements, second phase a quarter cycle apart from the first
// - edges at least 0.4 us apart at 1 um, 0.2 us finer; error pulses 0.4 us
// - retracting spindle makes phase A lead; extending makes phase B lead
// - valid real-time pulses guaranteed only at spindle speed up to 250 mm/s
// - emitted count catches up with true position within 1 us; the code only raises lag_overrun once it trails longer than that
// - on error both phases toggle together on the same edge
// - error state entered on overspeed or disturbed detection
// - origin phase pulses only at the mark, about 40 to 60 um wide
// - origin edge repeats within 0.5 um from same direction below 300 mm/s
package quad_out_pkg;
   localparam int CLK_PERIOD_NS      = 10;
   localparam int GAP_FINE_NS        = 200;   // min_realtime_edge_gap, finer resolutions
   localparam int GAP_COARSE_NS      = 400;   // min_realtime_edge_gap, 1 um resolution
   localparam int ERR_WIDTH_NS       = 400;   // min_error_pulse_width
   localparam int OUT_DELAY_NS       = 1000;  // longest output delay
   localparam int GAP_FINE_CYC       = (GAP_FINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_COARSE_CYC     = (GAP_COARSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERR_WIDTH_CYC      = (ERR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OUT_DELAY_CYC      = OUT_DELAY_NS / CLK_PERIOD_NS;
   localparam int CNT_W              = 8;
   localparam logic [1:0] RES_1UM    = 2'h0;
   localparam logic [1:0] RES_0P5UM  = 2'h1;
   localparam logic [1:0] RES_0P1UM  = 2'h2;
   typedef enum logic [1:0] {ST_TRACK, ST_ERROR} out_state_t;
endpackage : quad_out_pkg

//--- verification/quad_out_checker.sv
// port checker for the quadrature output
`timescale 1ns/1ps
module quad_out_checker (
   input wire logic [1:0] resolution_sel,
   input wire logic mclk, resetn, overspeed, detect_fault, origin_mark, error_active,
   input wire logic phase_a_true, phase_a_comp, phase_b_true, phase_b_comp, origin_pulse_out, origin_pulse_comp
);
   logic       a_reg, b_reg;
   logic [7:0] gap_reg;
   wire        ea  = phase_a_true ^ a_reg;
   wire        eb  = phase_b_true ^ b_reg;
   wire        bad = overspeed | detect_fault;
   // gap saturates so a long idle never wraps into a false short gap
   always_ff @(posedge mclk) begin
      a_reg   <= phase_a_true;
      b_reg   <= phase_b_true;
      gap_reg <= !resetn ? 8'hff : (ea | eb) ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hff};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   AST_COMP_A: assert property (phase_a_comp != phase_a_true) else $error("a pair");
   AST_COMP_B: assert property (phase_b_comp != phase_b_true) else $error("b pair");
   AST_COMP_Z: assert property (origin_pulse_comp != origin_pulse_out) else $error("z pair");
   AST_GAP: assert property (ea | eb |-> gap_reg >= ((resolution_sel == 2'h0) ? 8'h27 : 8'h13)) else $error("edges close");
   AST_ONE: assert property (ea & eb |-> error_active | $past(error_active)) else $error("double edge");
   AST_LOCK: assert property (error_active & $past(error_active) & ea |-> eb) else $error("lone edge");
   AST_ERR: assert property (bad |-> ##[1:2] error_active) else $error("no error");
   AST_Z_ON: assert property (origin_mark & !bad |-> ##2 origin_pulse_out) else $error("no origin");
   AST_Z_OFF: assert property (!origin_mark |-> ##2 !origin_pulse_out) else $error("stray origin");
endmodule : quad_out_checker
bind quadrature_displacement_output quad_out_checker chk (.*);

//--- verification/quad_counter_model.sv
// receiving up/down counter model
`timescale 1ns/1ps
module quad_counter_model (
   input  wire logic        mclk, resetn, phase_a, phase_b,
   output logic      [23:0] count
);
   logic [1:0] idx_reg;
   wire  [1:0] idx  = {phase_b, phase_a ^ phase_b};
   wire  [1:0] step = idx - idx_reg;
   // step 2 is a coincident edge, so error pulses are dropped
   always @(posedge mclk) begin
      idx_reg <= idx;
      if (!resetn) count <= 24'h00_0000;
      else if (step == 2'h1) count <= count + 24'h00_0001;
      else if (step == 2'h3) count <= count - 24'h00_0001;
   end
endmodule : quad_counter_model

//--- verification/quadrature_displacement_output_bench.sv
// self-checking bench for the quadrature output
`timescale 1ns/1ps
module quadrature_displacement_output_bench;
   logic        mclk = 0, resetn = 0, overspeed = 0, detect_fault = 0, origin_mark = 0;
   logic        phase_a_true, phase_a_comp, phase_b_true, phase_b_comp, origin_pulse_out, origin_pulse_comp;
   logic        error_active, lag_overrun;
   logic [1:0]  resolution_sel = '0;
   logic [23:0] scale_position = '0, expected = '0, count, notes[$];
   int          miscompares = 0, checks = 0, n;
   event        result_ev;
   initial forever #5 mclk = ~mclk;
   quadrature_displacement_output uut (.*);
   quad_counter_model rx (.mclk, .resetn, .phase_a(phase_a_true), .phase_b(phase_b_true), .count);
   task cmp(input logic [23:0] seen, want);
      checks++;
      if (seen !== want) miscompares++;
      if (seen !== want) $display("Error %0t seen %h want %h", $time, seen, want);
   endtask : cmp
   task summarize;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   task move(input logic [1:0] res, input logic [23:0] delta);
      @(negedge mclk);
      resolution_sel = res;
      scale_position = scale_position + delta;
      expected = expected + delta;
      notes.push_back(expected);
      for (n = 0; n < 9000 && count !== expected; n++) @(negedge mclk);
      -> result_ev;
      #1;
      if (n == 9000) summarize();
   endtask : move
   always @(result_ev) cmp(count, notes.pop_front());
   initial begin
      void'($urandom(71054));
      repeat (10) @(negedge mclk);
      resetn = 1;
      cmp({16'h0, phase_a_true, phase_a_comp, phase_b_true, phase_b_comp, origin_pulse_out, origin_pulse_comp,
           error_active, lag_overrun}, 24'h00_0054);
      for (int r = 0; r < 3; r++) begin
         move(2'(r), 24'($urandom_range(1, 9)));
         move(2'(r), 24'h00_0000 - 24'($urandom_range(1, 9)));
         $display("resolution %0d done", r);
      end
      for (int f = 0; f < 2; f++) begin
         repeat (40) @(negedge mclk);
         {overspeed, detect_fault, origin_mark} = {2'h1 << f, 1'b1};
         repeat (5) @(negedge mclk);
         scale_position = scale_position + 24'($urandom_range(1, 9));
         repeat (200) @(negedge mclk);
         cmp({22'h0, origin_pulse_out, error_active}, 24'h00_0001);
         {overspeed, detect_fault} = 2'h0;
         repeat (100) @(negedge mclk);
         cmp({22'h0, origin_pulse_out, error_active}, 24'h00_0002);
         origin_mark = 0;
         expected = count; // expectation re-homes to the receiver count after an error
         move(2'h1, 24'($urandom_range(1, 9)));
         $display("fault %0d done", f);
      end
      summarize();
   end
endmodule : quadrature_displacement_output_bench
